//--- src/adcsq_params.svh
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// register byte offsets on the apb window
`define ADCSQ_OFF_CTRL_PRI 12'h000
`define ADCSQ_OFF_CTRL_SEC 12'h004
`define ADCSQ_OFF_PIN_EN 12'h008
`define ADCSQ_OFF_RES_HI 12'h00c
`define ADCSQ_OFF_RES_LO 12'h010
`define ADCSQ_OFF_IRQ 12'h014

// conv_control_primary fields
`define ADCSQ_PRI_START 7
`define ADCSQ_PRI_BUSY 6
`define ADCSQ_PRI_PWR_OFF 5
`define ADCSQ_PRI_INT_REF 4
`define ADCSQ_PRI_CH_HI 2
`define ADCSQ_PRI_CH_LO 0

// conv_control_secondary fields
`define ADCSQ_SEC_BG_EN 6
`define ADCSQ_SEC_JUSTIFY 5
`define ADCSQ_SEC_REF_SEL 4
`define ADCSQ_SEC_DIV_HI 2
`define ADCSQ_SEC_DIV_LO 0

// interrupt control fields
`define ADCSQ_IRQ_EN 0
`define ADCSQ_IRQ_FLAG 1

// reset values
`define ADCSQ_RST_PWR_OFF 1'b1
`define ADCSQ_RST_BUSY 1'b1
`define ADCSQ_RST_CH 3'h0
`define ADCSQ_RST_DIV 3'h0
`define ADCSQ_RST_PIN_EN 8'h00

// conversion timing
`define ADCSQ_CONV_PERIODS 16
`define ADCSQ_DIV_MAX_CODE 3'h6

`endif

//--- src/adcsq_pkg.sv
package adcsq_pkg;

  // conversion sequencer states
  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_HOLD = 3'b010,
    ADCSQ_CONV = 3'b100
  } adcsq_state_t;

endpackage

//--- src/adcsq_conv_timer.sv
`timescale 1ns/1ns
`include "adcsq_params.svh"

module adcsq_conv_timer #(
  parameter int DIV_W = 6,
  parameter int PERIODS = `ADCSQ_CONV_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start_bit,
  input wire logic power_off,
  input wire logic [2:0] div_code,
  output logic tick_q,
  output logic busy_q,
  output logic done_q
);

  adcsq_pkg::adcsq_state_t state_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [4:0] period_cnt_q;
  logic [2:0] code_eff;
  logic [DIV_W-1:0] div_limit;
  logic tick_now;
  logic last_period;

  // code 111 has no defined rate; it runs as the slowest one
  assign code_eff = (div_code > `ADCSQ_DIV_MAX_CODE) ? `ADCSQ_DIV_MAX_CODE : div_code;
  assign div_limit = DIV_W'((1 << code_eff) - 1);
  // a powered-off converter makes no progress
  assign tick_now = (state_q == adcsq_pkg::ADCSQ_CONV) && !power_off &&
                    (div_cnt_q == div_limit);
  assign last_period = (period_cnt_q == 5'(PERIODS - 1));

  // sequencer: start high holds, its fall launches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adcsq_pkg::ADCSQ_IDLE;
    end else begin
      unique case (state_q)
        adcsq_pkg::ADCSQ_IDLE: begin
          if (start_bit) state_q <= adcsq_pkg::ADCSQ_HOLD;
        end
        adcsq_pkg::ADCSQ_HOLD: begin
          if (!start_bit) state_q <= adcsq_pkg::ADCSQ_CONV;
        end
        adcsq_pkg::ADCSQ_CONV: begin
          if (start_bit) state_q <= adcsq_pkg::ADCSQ_HOLD;
          else if (tick_now && last_period) state_q <= adcsq_pkg::ADCSQ_IDLE;
        end
      endcase
    end
  end

  // prescaler and period counter, cleared outside a conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
      period_cnt_q <= '0;
    end else if (state_q != adcsq_pkg::ADCSQ_CONV || start_bit) begin
      div_cnt_q <= '0;
      period_cnt_q <= '0;
    end else if (!power_off) begin
      div_cnt_q <= tick_now ? '0 : div_cnt_q + 1'b1;
      if (tick_now) period_cnt_q <= period_cnt_q + 1'b1;
    end
  end

  // busy flag: forced by start, cleared at the last period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= `ADCSQ_RST_BUSY;
      done_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_now && !start_bit;
      done_q <= tick_now && last_period && !start_bit;
      if (start_bit) busy_q <= 1'b1;
      else if (tick_now && last_period) busy_q <= 1'b0;
    end
  end

endmodule

//--- src/adcsq_top.sv
`timescale 1ns/1ns
`include "adcsq_params.svh"

// Overview of operation
// - justify 0: msb at high bit 7
// - justify 1: right aligned, lsb at bit 0
// - unused result bits read as zero
// - conversion starts after start set then cleared
// - start high resets core, forces busy
// - busy reads 1 during conversion, then clears
// - end sets request flag, irq if enabled
// - power-off bit, resets to 1
// - internal-ref bit routes bandgap, drops pins
// - channel field selects analog input directly
// - bandgap on when enabled or lvr/lvd used
// - reference select: supply or external pin
// - conversion clock is system clock over 2^code, 2^6 for code 111
// - analog-enable bits claim their mapped pins
// - analog pin drops its pull-high resistor
// - unimplemented control bits read zero
// - conversion lasts sixteen conversion clock periods
// - analog enable overrides port direction
module adcsq_top #(
  parameter int RES_W = 12,
  parameter int NPINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RES_W-1:0] core_result,
  input wire logic low_voltage_reset_en,
  input wire logic low_voltage_detect_en,
  input wire logic [NPINS-1:0] pin_pullup_cfg,
  input wire logic [NPINS-1:0] pin_dir_input_cfg,
  output logic core_reset_q,
  output logic core_power_down_q,
  output logic core_conv_tick_q,
  output logic [NPINS-1:0] analog_inputs_sel_q,
  output logic bandgap_route_q,
  output logic bandgap_on_q,
  output logic reference_ext_sel_q,
  output logic port_e_pin0_analog_q,
  output logic port_a_pin6_analog_q,
  output logic [5:0] port_b_pins_2_to_7_analog_q,
  output logic [NPINS-1:0] pin_pullup_eff_q,
  output logic [NPINS-1:0] pin_dir_input_eff_q,
  output logic conv_irq_q
);

  // primary control fields
  logic start_q;
  logic conv_power_off_q;
  logic internal_ref_channel_sel_q;
  logic [2:0] channel_select_field_q;

  // secondary control fields
  logic bandgap_enable_q;
  logic result_justify_sel_q;
  logic reference_source_sel_q;
  logic [2:0] conv_clock_divider_q;

  // pin enables, interrupt and result
  logic [NPINS-1:0] analog_pin_enable_q;
  logic irq_enable_q;
  logic irq_flag_q;
  logic [RES_W-1:0] result_q;

  // conversion timer; the busy flag is the read-only bit of the primary word
  // and software has no way to write it
  logic conv_tick;
  logic conv_busy_flag;
  logic conv_done;

  // bus decode
  logic setup_phase;
  logic wr_access;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] ctrl_pri_rd;
  logic [7:0] ctrl_sec_rd;
  logic [7:0] res_hi_rd;
  logic [7:0] res_lo_rd;
  logic wr_pri;
  logic wr_sec;
  logic wr_pin;
  logic wr_irq;
  logic [7:0] irq_rd;

  // per pin next values of the port overrides
  logic [NPINS-1:0] pin_pullup_d;
  logic [NPINS-1:0] pin_dir_input_d;

  adcsq_conv_timer #(
    .DIV_W(6),
    .PERIODS(`ADCSQ_CONV_PERIODS)
  ) adcsq_conv_timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start_bit(start_q),
    .power_off(conv_power_off_q),
    .div_code(conv_clock_divider_q),
    .tick_q(conv_tick),
    .busy_q(conv_busy_flag),
    .done_q(conv_done)
  );

  // apb phases; the slave answers in the first access cycle
  // no wait states: pready is the setup cycle seen one edge later
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite && pstrb[0];

  // address decode, only byte lane 0 carries register data
  // an unmapped address answers with an error and reads as zero
  always_comb begin
    addr_hit = 1'b1;
    unique case (paddr)
      `ADCSQ_OFF_CTRL_PRI: rd_byte = ctrl_pri_rd;
      `ADCSQ_OFF_CTRL_SEC: rd_byte = ctrl_sec_rd;
      `ADCSQ_OFF_PIN_EN: rd_byte = analog_pin_enable_q;
      `ADCSQ_OFF_RES_HI: rd_byte = res_hi_rd;
      `ADCSQ_OFF_RES_LO: rd_byte = res_lo_rd;
      `ADCSQ_OFF_IRQ: rd_byte = irq_rd;
      default: begin
        rd_byte = 8'h00;
        addr_hit = 1'b0;
      end
    endcase
  end

  // writes decode only on the access edge, with byte lane 0 strobed
  assign wr_pri = wr_access && (paddr == `ADCSQ_OFF_CTRL_PRI);
  assign wr_sec = wr_access && (paddr == `ADCSQ_OFF_CTRL_SEC);
  assign wr_pin = wr_access && (paddr == `ADCSQ_OFF_PIN_EN);
  assign wr_irq = wr_access && (paddr == `ADCSQ_OFF_IRQ);

  // read views; bit 3 is not built and always reads zero
  assign ctrl_pri_rd = {start_q, conv_busy_flag, conv_power_off_q,
                        internal_ref_channel_sel_q, 1'b0,
                        channel_select_field_q};
  assign ctrl_sec_rd = {1'b0, bandgap_enable_q, result_justify_sel_q,
                        reference_source_sel_q, 1'b0,
                        conv_clock_divider_q};
  // request flag above its enable in the interrupt word
  assign irq_rd = {6'h00, irq_flag_q, irq_enable_q};

  // result byte layout picked by the justify bit at read time
  // the held value is never rewritten, so the format may change between reads
  always_comb begin
    if (result_justify_sel_q) begin
      res_hi_rd = {4'h0, result_q[11:8]};
      res_lo_rd = result_q[7:0];
    end else begin
      res_hi_rd = result_q[11:4];
      res_lo_rd = {result_q[3:0], 4'h0};
    end
  end

  // bus answer registered in setup, so prdata is a flop output
  // prdata then holds until the next setup, so a late look still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata <= {24'h00_0000, rd_byte};
        pslverr <= !addr_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // primary control; the busy bit is read only
  // start written high mid-conversion aborts that conversion in the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      conv_power_off_q <= `ADCSQ_RST_PWR_OFF;
      internal_ref_channel_sel_q <= 1'b0;
      channel_select_field_q <= `ADCSQ_RST_CH;
    end else if (wr_pri) begin
      start_q <= pwdata[`ADCSQ_PRI_START];
      conv_power_off_q <= pwdata[`ADCSQ_PRI_PWR_OFF];
      internal_ref_channel_sel_q <= pwdata[`ADCSQ_PRI_INT_REF];
      channel_select_field_q <= pwdata[`ADCSQ_PRI_CH_HI:`ADCSQ_PRI_CH_LO];
    end
  end

  // secondary control; bits 7 and 3 are dropped on write
  // code 111 is stored as written; the timer runs it at the slowest rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_enable_q <= 1'b0;
      result_justify_sel_q <= 1'b0;
      reference_source_sel_q <= 1'b0;
      conv_clock_divider_q <= `ADCSQ_RST_DIV;
    end else if (wr_sec) begin
      bandgap_enable_q <= pwdata[`ADCSQ_SEC_BG_EN];
      result_justify_sel_q <= pwdata[`ADCSQ_SEC_JUSTIFY];
      reference_source_sel_q <= pwdata[`ADCSQ_SEC_REF_SEL];
      conv_clock_divider_q <= pwdata[`ADCSQ_SEC_DIV_HI:`ADCSQ_SEC_DIV_LO];
    end
  end

  // analog pin enables
  // a set bit hands the pin to the converter through the overrides below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_pin_enable_q <= `ADCSQ_RST_PIN_EN;
    end else if (wr_pin) begin
      analog_pin_enable_q <= pwdata[NPINS-1:0];
    end
  end

  // result loads only when a conversion completes, else holds
  // the core output may wander outside the end cycle without harm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (conv_done) begin
      result_q <= core_result;
    end
  end

  // request flag: write one clears, a completion in the same cycle wins
  // losing a completion to a clear would hide a finished result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= 1'b0;
      irq_flag_q <= 1'b0;
    end else begin
      if (wr_irq) irq_enable_q <= pwdata[`ADCSQ_IRQ_EN];
      if (conv_done) irq_flag_q <= 1'b1;
      else if (wr_irq && pwdata[`ADCSQ_IRQ_FLAG]) irq_flag_q <= 1'b0;
    end
  end

  // interrupt line toward the controller, gated by the enable
  // one edge behind the flag; the controller only looks at the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_q <= 1'b0;
    end else begin
      conv_irq_q <= irq_flag_q && irq_enable_q;
    end
  end

  // converter core controls; start high keeps the core in reset
  // registered, so the core never sees a glitch from the bus decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_q <= 1'b0;
      core_power_down_q <= `ADCSQ_RST_PWR_OFF;
      core_conv_tick_q <= 1'b0;
      reference_ext_sel_q <= 1'b0;
    end else begin
      core_reset_q <= start_q;
      core_power_down_q <= conv_power_off_q;
      core_conv_tick_q <= conv_tick;
      reference_ext_sel_q <= reference_source_sel_q;
    end
  end

  // input mux: bandgap route disconnects every external channel
  // one-hot select: at most one channel switch is ever closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_inputs_sel_q <= '0;
      bandgap_route_q <= 1'b0;
    end else begin
      bandgap_route_q <= internal_ref_channel_sel_q;
      if (internal_ref_channel_sel_q) begin
        analog_inputs_sel_q <= '0;
      end else begin
        analog_inputs_sel_q <= NPINS'(1) << channel_select_field_q;
      end
    end
  end

  // bandgap stays up while the converter or the supply monitors need it
  // dropping it under a running supply monitor would upset its checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_on_q <= 1'b0;
    end else begin
      bandgap_on_q <= bandgap_enable_q || low_voltage_reset_en ||
                      low_voltage_detect_en;
    end
  end

  // pin ownership: enable bit 0 is port e pin 0, bit 1 port a pin 6,
  // bits 2..7 port b pins 2..7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_pin0_analog_q <= 1'b0;
      port_a_pin6_analog_q <= 1'b0;
      port_b_pins_2_to_7_analog_q <= 6'h00;
    end else begin
      port_e_pin0_analog_q <= analog_pin_enable_q[0];
      port_a_pin6_analog_q <= analog_pin_enable_q[1];
      port_b_pins_2_to_7_analog_q <= analog_pin_enable_q[7:2];
    end
  end

  // per pin overrides of pull-high and direction
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      // an analog pin must not load the source with a pull-high
      assign pin_pullup_d[gi] = pin_pullup_cfg[gi] && !analog_pin_enable_q[gi];
      // the analog claim wins over whatever direction software left
      assign pin_dir_input_d[gi] = pin_dir_input_cfg[gi] || analog_pin_enable_q[gi];
    end
  endgenerate

  // one register stage for all pins keeps each output with one writer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pullup_eff_q <= '0;
      pin_dir_input_eff_q <= '1;
    end else begin
      pin_pullup_eff_q <= pin_pullup_d;
      pin_dir_input_eff_q <= pin_dir_input_d;
    end
  end

endmodule

//--- tb/adcsq_top_asserts.sv
`timescale 1ns/1ns

module adcsq_chk #(
  parameter int NPINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic low_voltage_reset_en,
  input wire logic low_voltage_detect_en,
  input wire logic [NPINS-1:0] pin_pullup_cfg,
  input wire logic core_reset_q,
  input wire logic core_power_down_q,
  input wire logic core_conv_tick_q,
  input wire logic [NPINS-1:0] analog_inputs_sel_q,
  input wire logic bandgap_route_q,
  input wire logic bandgap_on_q,
  input wire logic port_e_pin0_analog_q,
  input wire logic port_a_pin6_analog_q,
  input wire logic [5:0] port_b_pins_2_to_7_analog_q,
  input wire logic [NPINS-1:0] pin_pullup_eff_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // start write reaches the core reset two edges after it lands
  AST_START_RESET: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && pstrb[0] && pwdata[7] |=> ##1 core_reset_q) else $error("core not held in reset");
  // no conversion clock while the core is held; two edges of lag drain first
  AST_HELD_NO_TICK: assert property (core_reset_q && $past(core_reset_q)
    && $past(core_reset_q, 2) |-> !core_conv_tick_q) else $error("tick while start high");
  // power-down follows a primary write two edges after it lands
  AST_PWR_FOLLOW: assert property (psel && penable && pready && pwrite
    && paddr == 12'h000 && pstrb[0] |=> ##1 core_power_down_q == $past(pwdata[5], 2))
    else $error("power-down not following the control bit");
  AST_PWR_RST: assert property (!$past(presetn) |-> core_power_down_q)
    else $error("converter not powered down after reset");
  AST_ONE_CH: assert property ($onehot0(analog_inputs_sel_q))
    else $error("more than one channel routed");
  AST_REF_DROPS_PINS: assert property (bandgap_route_q |-> analog_inputs_sel_q == '0)
    else $error("pins still routed with internal reference");
  AST_PULLUP_OFF: assert property ($past(presetn) |-> pin_pullup_eff_q ==
    ($past(pin_pullup_cfg) & ~{port_b_pins_2_to_7_analog_q, port_a_pin6_analog_q,
    port_e_pin0_analog_q})) else $error("pull-high kept on analog pin");
  AST_BG_LV: assert property ($past(presetn) && $past(low_voltage_reset_en
    || low_voltage_detect_en) |-> bandgap_on_q) else $error("bandgap off with lv in use");
  AST_PRI_RSVD: assert property (psel && !penable && !pwrite && paddr == 12'h000
    |=> prdata[3] == 1'b0 && prdata[31:8] == 24'h0) else $error("reserved bit not zero");
endmodule

bind adcsq_top adcsq_chk #(.NPINS(NPINS)) adcsq_chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .low_voltage_reset_en,
  .low_voltage_detect_en, .pin_pullup_cfg, .core_reset_q, .core_power_down_q,
  .core_conv_tick_q, .analog_inputs_sel_q, .bandgap_route_q, .bandgap_on_q,
  .port_e_pin0_analog_q, .port_a_pin6_analog_q, .port_b_pins_2_to_7_analog_q,
  .pin_pullup_eff_q);

//--- tb/tb.sv
`timescale 1ns/1ns

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, core_result;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic low_voltage_reset_en, low_voltage_detect_en, core_reset_q, core_power_down_q;
  logic core_conv_tick_q, bandgap_route_q, bandgap_on_q, reference_ext_sel_q, conv_irq_q;
  logic port_e_pin0_analog_q, port_a_pin6_analog_q;
  logic [5:0] port_b_pins_2_to_7_analog_q;
  logic [7:0] pin_pullup_cfg, pin_dir_input_cfg, analog_inputs_sel_q, pin_pullup_eff_q;
  logic [7:0] pin_dir_input_eff_q, en, cp, cd;
  logic [32:0] q[$];
  int fails, n_checks, nt;
  time t0, t1;

  adcsq_top adcsq_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .core_result, .low_voltage_reset_en, .low_voltage_detect_en,
    .pin_pullup_cfg, .pin_dir_input_cfg, .core_reset_q, .core_power_down_q, .core_conv_tick_q,
    .analog_inputs_sel_q, .bandgap_route_q, .bandgap_on_q, .reference_ext_sel_q,
    .port_e_pin0_analog_q, .port_a_pin6_analog_q, .port_b_pins_2_to_7_analog_q,
    .pin_pullup_eff_q, .pin_dir_input_eff_q, .conv_irq_q);

  // 10 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask

  task test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer; reads leave their expected answer in the queue
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [32:0] e);
    if (!w)
      q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no count of its own: only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h1, '0);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, '0, 4'h1, {25'h0, e});
  endtask

  // counts conversion ticks until the interrupt line rises or n cycles pass
  task ticks(input int n);
    int c;
    c = 0;
    nt = 0;
    while (conv_irq_q !== 1'b1 && c < n) begin
      @(posedge pclk);
      c++;
      if (core_conv_tick_q === 1'b1) begin
        if (nt == 0)
          t0 = $time;
        t1 = $time;
        nt++;
      end
    end
  endtask

  task conv(input logic [2:0] dv, input logic jf, input logic [11:0] r);
    wr(12'h004, 32'({jf, 2'b00, dv}));
    core_result <= r;
    wr(12'h000, 32'h80);
    rd(12'h000, 8'hc0);
    chk("pwr", core_power_down_q, 1'b0);
    wr(12'h000, 32'h00);
    ticks(3000);
    chk("ticks", nt, 16);
    // first to last tick is fifteen periods; code 111 runs as 110
    chk("span", (t1 - t0) / 100, 64'(15) << ((dv == 3'h7) ? 3'h6 : dv));
    core_result <= ~r;
    rd(12'h00c, jf ? {4'h0, r[11:8]} : r[11:4]);
    rd(12'h010, jf ? r[7:0] : {r[3:0], 4'h0});
    rd(12'h000, 8'h00);
    rd(12'h014, 8'h03);
    wr(12'h014, 32'h03);
    repeat (2) @(posedge pclk);
    chk("irq", conv_irq_q, 1'b0);
  endtask

  // compares each read answer with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", {pslverr, prdata}, q.pop_front());
  end

  // watchdog, well beyond the longest conversion sweep
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, core_result} = '0;
    {low_voltage_reset_en, low_voltage_detect_en, pin_pullup_cfg, pin_dir_input_cfg} = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(73));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 8'h60);
    rd(12'h004, 8'h00);
    wr(12'h004, 32'hff); // bandgap on before the internal channel
    apb(1'b1, 12'h004, 32'h0, 4'he, '0);
    rd(12'h004, 8'h77);
    wr(12'h000, 32'h1f);
    rd(12'h000, 8'h57);
    repeat (2) @(posedge pclk);
    chk("route", {bandgap_route_q, analog_inputs_sel_q}, 9'h100);
    chk("vref", {reference_ext_sel_q, bandgap_on_q}, 2'h3);
    for (int ch = 0; ch < 8; ch++) begin
      wr(12'h000, 32'h20 | ch);
      repeat (2) @(posedge pclk);
      chk("chan", analog_inputs_sel_q, 8'h01 << ch);
    end
    // random pin claims against random port settings
    repeat (4) begin
      {en, cp, cd} = 24'($urandom);
      pin_pullup_cfg <= cp;
      pin_dir_input_cfg <= cd;
      {low_voltage_reset_en, low_voltage_detect_en} <= 2'($urandom);
      wr(12'h008, {24'h0, en});
      repeat (2) @(posedge pclk);
      chk("pins", {port_b_pins_2_to_7_analog_q, port_a_pin6_analog_q,
        port_e_pin0_analog_q}, en);
      chk("pull", pin_pullup_eff_q, cp & ~en);
      chk("dir", pin_dir_input_eff_q, cd | en);
      rd(12'h008, en);
    end
    apb(1'b0, 12'h018, '0, 4'h1, {1'b1, 32'h0});
    wr(12'h00c, 32'hff);
    wr(12'h014, 32'h01);
    // codes 0..2 undercut the minimum period at this clock; the result here
    // comes from the bench, so only the digital count is at stake
    for (int dv = 0; dv < 8; dv++)
      conv(3'(dv), dv[0], 12'($urandom));
    // a lone start clear must not launch anything; power off before idling
    wr(12'h000, 32'h20);
    ticks(60);
    chk("idle", nt, 0);
    chk("pwr", core_power_down_q, 1'b1);
    test_done;
  end
endmodule
